/* src/dskp_port.sv */
/*
  seek command port of a cartridge disk drive: active-low controller
  lines, track capture, legality check, acknowledge reporting,
  timeout flag, plus a small register port with interrupts.
  assumes pin inputs are asynchronous; positioner feedback (settled)
  and sector/index pulses come from logic on the same clock.
*/
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/100ps
module dskp_port #(
  parameter logic [1:0] UNIT_ID = 2'h0,
  parameter bit PLATTER_EN = 1'b1,
  parameter bit SURFACE_EN = 1'b1,
  parameter bit AUTO_ZERO = 1'b1,
  parameter bit RETRACT_EN = 1'b1,
  parameter bit SECTOR_MUX = 1'b1,
  parameter dskp_pkg::dskp_rep_t REPORT = dskp_pkg::DSKP_REP_PULSE,
  parameter bit BAD_TIMEOUT = 1'b1,
  parameter bit DONE_BUSY = 1'b0,
  parameter bit ZERO_ON_PICK = 1'b0,
  parameter bit ZERO_CLEARS_TMO = 1'b1,
  parameter int TIMEOUT_CYC = dskp_pkg::TIMEOUT_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [8:0] track_n,
  input wire logic seek_n,
  input wire logic zero_n,
  input wire logic [3:0] unit_pick_n,
  input wire logic platter_n,
  input wire logic surface_n,
  input wire logic supply_n,
  input wire logic settled,
  input wire logic fix_sector,
  input wire logic fix_index,
  input wire logic rem_sector,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic irq,
  output dskp_pkg::dskp_pos_t pos,
  output logic use_fixed,
  output logic use_bottom,
  output logic done_n,
  output logic timeout_n,
  output logic bad_track_pulse_n,
  output logic accept_n,
  output logic sector_n,
  output logic fix_sector_n
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  localparam int PW = 9 + 1 + 1 + 4 + 1 + 1 + 1;
  logic [PW-1:0] pin_s;
  logic [8:0] trk_s;
  logic seek_s, zero_s, plat_s, surf_s, supply_s;
  logic [3:0] pick_s;

  dskp_sync #(.WIDTH(PW), .INIT({PW{1'b1}})) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in({track_n, seek_n, zero_n, unit_pick_n, platter_n, surface_n, supply_n}),
    .sync_out(pin_s)
  );

  // active-low lines turned to asserted-high here only
  assign {trk_s, seek_s, zero_s, pick_s, plat_s, surf_s, supply_s} = ~pin_s;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ACK_IDLE = 2'b00,
    ACK_WAIT = 2'b01,
    ACK_SHOW = 2'b10
  } dskp_ack_t;

  typedef struct packed {
    logic seek_d1;
    logic [8:0] track;
    logic bad;
    logic busy;
    logic tmo;
    logic retracted;
    dskp_ack_t ack;
    logic [15:0] ack_cnt;
    logic bad_lvl;
    logic acc_lvl;
    logic [3:0] status;
    logic [3:0] enable;
    logic [31:0] rdata;
    dskp_pkg::dskp_pos_t pos;
  } dskp_st_t;
  dskp_st_t st_q;
  dskp_st_t st_d;

  logic picked, seek_rise, zero_req, bad_now, auto_zero, tmo_exp, tmo_run;
  logic [3:0] events;

  // respond only to our own unit pick line
  assign picked = pick_s[UNIT_ID];
  assign seek_rise = seek_s & ~st_q.seek_d1 & picked;
  // return to zero qualified by strobe or by pick, per build option
  assign zero_req = zero_s & picked & (ZERO_ON_PICK ? 1'b1 : seek_rise);
  // legality judged on the live bus at the strobe edge
  assign bad_now = trk_s > dskp_pkg::TRACK_LAST;
  assign auto_zero = seek_rise & bad_now & AUTO_ZERO;

  // ---------------------------------------------------------------
  // timeout counter, started by each picked strobe, legal track or not
  // ---------------------------------------------------------------
  dskp_timer #(.WIDTH(32)) u_tmo (
    .clock(clock),
    .rst_n(rst_n),
    .load(seek_rise),
    .count(TIMEOUT_CYC),
    .stop(settled & ~st_q.busy),
    .running(tmo_run),
    .expire(tmo_exp)
  );

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.seek_d1 = seek_s;
    st_d.pos.pos_en = 1'b0;
    st_d.rdata = 32'h0000_0000;
    // capture and start positioning on strobe
    if (seek_rise) begin
      st_d.track = trk_s;
      st_d.bad = bad_now;
      st_d.busy = 1'b1;
      st_d.tmo = 1'b0; // fresh strobe clears the flag
      st_d.pos.pos_en = ~bad_now | AUTO_ZERO;
      st_d.pos.pos_zero = bad_now;
      st_d.pos.pos_track = bad_now ? dskp_pkg::TRACK_ZERO : trk_s;
      st_d.bad_lvl = bad_now;
      st_d.acc_lvl = ~bad_now;
      st_d.ack = ACK_WAIT;
      st_d.ack_cnt = 16'(dskp_pkg::ACK_DELAY_CYC);
    end
    // return to zero, explicit or automatic
    if (zero_req | auto_zero) begin
      st_d.pos.pos_en = 1'b1;
      st_d.pos.pos_zero = 1'b1;
      st_d.pos.pos_track = dskp_pkg::TRACK_ZERO;
      st_d.busy = 1'b1;
      if (ZERO_CLEARS_TMO) begin
        st_d.tmo = 1'b0;
      end
    end
    // illegal-track flag set after the clear, so an auto zero cannot hide it
    if (seek_rise & bad_now & BAD_TIMEOUT) begin
      st_d.tmo = 1'b1;
    end
    if (st_q.busy & settled & ~seek_rise & ~zero_req) begin
      st_d.busy = 1'b0;
    end
    // unsettled after 330 ms raises timeout
    if (tmo_exp & st_q.busy) begin
      st_d.tmo = 1'b1;
    end
    // retract while the supply sense pin sits at ground, option
    st_d.retracted = RETRACT_EN & supply_s;
    st_d.pos.retract = st_d.retracted;
    // acknowledge pulse sequencing
    case (st_q.ack)
      ACK_IDLE: begin
      end
      ACK_WAIT: begin
        if (!seek_rise) begin
          if (st_q.ack_cnt <= 16'h0001) begin
            st_d.ack = ACK_SHOW;
            st_d.ack_cnt = 16'(dskp_pkg::ACK_WIDTH_CYC);
          end else begin
            st_d.ack_cnt = st_q.ack_cnt - 16'h0001;
          end
        end
      end
      ACK_SHOW: begin
        if (!seek_rise) begin
          if (st_q.ack_cnt <= 16'h0001) begin
            st_d.ack = ACK_IDLE;
          end else begin
            st_d.ack_cnt = st_q.ack_cnt - 16'h0001;
          end
        end
      end
      default: st_d.ack = ACK_IDLE;
    endcase
    // register writes; hardware set beats software clear
    if (wr && addr == dskp_pkg::REG_ENABLE) begin
      st_d.enable = wdata[3:0];
    end
    if (wr && addr == dskp_pkg::REG_CLEAR) begin
      st_d.status = st_q.status & ~wdata[3:0];
    end
    // events taken from the finished next state, no loop back through st_d
    events = {st_d.retracted & ~st_q.retracted, st_d.tmo & ~st_q.tmo,
              seek_rise & bad_now, st_q.busy & settled};
    st_d.status = st_d.status | events;
    // register reads, data in the following cycle only
    if (rd) begin
      case (addr)
        dskp_pkg::REG_STATUS: st_d.rdata = {28'h0000000, st_q.status};
        dskp_pkg::REG_ENABLE: st_d.rdata = {28'h0000000, st_q.enable};
        dskp_pkg::REG_TRACK: st_d.rdata = {20'h00000, st_q.busy, st_q.tmo,
                                           st_q.bad, st_q.track};
        default: st_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all active low toward the controller
  // ---------------------------------------------------------------
  logic show;
  logic bad_o, acc_o, sec_o, fsec_o;
  assign show = st_q.ack == ACK_SHOW;
  // pulses, levels, or fixed-platter pulses on shared pins
  always_comb begin
    case (REPORT)
      dskp_pkg::DSKP_REP_PULSE: begin
        bad_o = show & st_q.bad;
        acc_o = show & ~st_q.bad;
      end
      dskp_pkg::DSKP_REP_LEVEL: begin
        bad_o = st_q.bad_lvl;
        acc_o = st_q.acc_lvl;
      end
      default: begin
        bad_o = fix_index;
        acc_o = fix_sector;
      end
    endcase
  end
  // platter choice drives sector mux when enabled
  assign use_fixed = PLATTER_EN & plat_s;
  assign sec_o = SECTOR_MUX ? (use_fixed ? fix_sector : rem_sector) : rem_sector;
  assign fsec_o = SECTOR_MUX ? 1'b0 : fix_sector;
  // surface choice not gated with unit pick
  assign use_bottom = SURFACE_EN & surf_s;
  assign bad_track_pulse_n = ~bad_o;
  assign accept_n = ~acc_o;
  assign sector_n = ~(sec_o & picked);
  assign fix_sector_n = ~(fsec_o & picked);
  // done gated by pick, optional busy sense
  assign done_n = ~(picked & (DONE_BUSY ? st_q.busy : ~st_q.busy));
  assign timeout_n = ~(picked & st_q.tmo);
  assign pos = st_q.pos;
  assign rdata = st_q.rdata;
  assign irq = |(st_q.status & st_q.enable);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  capture_track_a: assert property (seek_rise |=> st_q.track == $past(trk_s))
    else $error("track not captured on strobe");
  bad_class_a: assert property (seek_rise |=> st_q.bad == ($past(trk_s) > 9'h197))
    else $error("illegal track misclassified");
  auto_zero_a: assert property (auto_zero |=> st_q.pos.pos_en && st_q.pos.pos_zero)
    else $error("no automatic return to zero");
  zero_go_a: assert property (zero_req |=> st_q.pos.pos_track == 9'h000)
    else $error("return to zero not issued");
  pick_gate_a: assert property (!picked |-> done_n && timeout_n)
    else $error("output active while not picked");
  ack_delay_a: assert property (seek_rise ##1 !seek_rise [*8] |-> !show)
    else $error("acknowledge too early");
  bad_tmo_a: assert property (seek_rise && bad_now |=> st_q.tmo == BAD_TIMEOUT)
    else $error("illegal track timeout option wrong");
  retract_a: assert property (supply_s |=> st_q.pos.retract == RETRACT_EN)
    else $error("retract does not follow supply sense");
  done_level_a: assert property (picked && !st_q.busy |-> done_n == DONE_BUSY)
    else $error("done output wrong while settled");
  seek_cov: cover property (seek_rise && !bad_now);
  bad_cov: cover property (seek_rise && bad_now);
  show_cov: cover property (show);
  tmo_cov: cover property (tmo_exp);
endmodule

/* inc/dskp_pkg.sv */
/*
  package for the seek command port: option encodings, timing counts,
  carrier structs. assumes a 200 MHz single clock.
*/
package dskp_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int STROBE_MIN_NS = 600;
  localparam int STROBE_MIN_CYC = (STROBE_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int ACK_DELAY_NS = 23000;
  localparam int ACK_DELAY_CYC = (ACK_DELAY_NS * CLK_MHZ) / 1000;
  localparam int ACK_WIDTH_NS = 2300;
  localparam int ACK_WIDTH_CYC = (ACK_WIDTH_NS * CLK_MHZ) / 1000;
  localparam int TIMEOUT_MS = 330;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * CLK_MHZ * 1000;
  // ---------------------------------------------------------------
  // track numbers
  // ---------------------------------------------------------------
  localparam int TRACK_W = 9;
  localparam logic [8:0] TRACK_LAST = 9'h197;
  localparam logic [8:0] TRACK_ZERO = 9'h000;
  localparam int UNIT_W = 4;
  // ---------------------------------------------------------------
  // option encodings
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    DSKP_REP_PULSE = 2'h0,
    DSKP_REP_LEVEL = 2'h1,
    DSKP_REP_FIXED = 2'h2
  } dskp_rep_t;
  // ---------------------------------------------------------------
  // interrupt bit positions
  // ---------------------------------------------------------------
  localparam int IRQ_W = 4;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_BAD = 1;
  localparam int IRQ_TMO = 2;
  localparam int IRQ_RETRACT = 3;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_CLEAR = 4'h4;
  localparam logic [3:0] REG_ENABLE = 4'h8;
  localparam logic [3:0] REG_TRACK = 4'hC;
  // ---------------------------------------------------------------
  // carrier structs
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       pos_en;
    logic       pos_zero;
    logic [8:0] pos_track;
    logic       retract;
  } dskp_pos_t;
  typedef struct packed {
    logic [3:0] addr;
    logic       wr;
    logic       rd;
    logic [31:0] wdata;
  } dskp_bus_t;
endpackage

/* src/dskp_sync.sv */
/*
  two-stage synchroniser bank for pin inputs.
  assumes inputs are asynchronous to clock.
*/
`timescale 1ns/100ps
module dskp_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } dskp_sync_st_t;
  dskp_sync_st_t st_q;
  dskp_sync_st_t st_d;

  // first stage read only by the second
  always_comb begin
    st_d = st_q;
    st_d.s1 = async_in;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= {INIT, INIT};
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.s2;
endmodule

/* src/dskp_timer.sv */
/*
  loadable down counter with a one-cycle expiry pulse.
  assumes load and stop come from logic on the same clock.
*/
`timescale 1ns/100ps
module dskp_timer #(
  parameter int WIDTH = 32
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [WIDTH-1:0] count,
  input wire logic stop,
  output logic running,
  output logic expire
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic run;
    logic exp;
  } dskp_tmr_st_t;
  dskp_tmr_st_t st_q;
  dskp_tmr_st_t st_d;

  // load wins over stop so a fresh start is never lost
  always_comb begin
    st_d = st_q;
    st_d.exp = 1'b0;
    if (load) begin
      st_d.cnt = count;
      st_d.run = 1'b1;
    end else if (stop) begin
      st_d.run = 1'b0;
    end else if (st_q.run) begin
      if (st_q.cnt <= 1) begin
        st_d.run = 1'b0;
        st_d.exp = 1'b1;
      end else begin
        st_d.cnt = st_q.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign running = st_q.run;
  assign expire = st_q.exp;
endmodule

/* tb/dskp_ctl_model.sv */
/*
  controller model for the seek command port: drives the active-low
  track, strobe, return-to-zero and unit pick lines.
  assumes the bench clock; released lines float to the negated level.
*/
`timescale 1ns/100ps
module dskp_ctl_model #(
  parameter logic [1:0] UNIT_ID = 2'h0
) (
  input wire logic clock,
  output logic [8:0] track_n,
  output logic seek_n,
  output logic zero_n,
  output logic [3:0] unit_pick_n
);
  // ---------------------------------------------------------------
  // idle levels
  // ---------------------------------------------------------------
  // terminated open-collector lines rest high, i.e. negated
  initial begin
    track_n = 9'h1FF;
    seek_n = 1'b1;
    zero_n = 1'b1;
    unit_pick_n = 4'hF;
  end
  // ---------------------------------------------------------------
  // seek transfer
  // ---------------------------------------------------------------
  // pick stays asserted afterwards so gated outputs remain visible
  task automatic seek(input logic [8:0] trk, input bit pick, input bit zero, input int extra);
    @(posedge clock);
    unit_pick_n <= pick ? ~(4'h1 << UNIT_ID) : 4'hF;
    track_n <= ~trk;
    zero_n <= ~zero;
    @(posedge clock);
    seek_n <= 1'b0;
    repeat (dskp_pkg::STROBE_MIN_CYC + extra) @(posedge clock);
    seek_n <= 1'b1;
    @(posedge clock);
    track_n <= 9'h1FF;
    zero_n <= 1'b1;
  endtask
endmodule

/* tb/testbench.sv */
/*
  self-checking bench for the seek command port: table of seeks through
  the controller model, then registers, interrupts, return-to-zero,
  supply loss, platter/surface and a mid-run reset by hand.
  assumes the acknowledge timing constants of the package.
*/
`timescale 1ns/100ps
module testbench;
  typedef struct packed {
    logic [8:0] track;
    logic pick;
    logic settle;
  } dskp_row_t;
  logic clock, rst_n, seek_n, zero_n, platter_n, surface_n, supply_n, settled;
  logic fix_sector, rem_sector, wr, rd, irq, use_fixed, use_bottom, done_n, timeout_n;
  logic bad_track_pulse_n, accept_n, sector_n, seek_q, acc_q, bad_q, last_zero, bad;
  logic fix_sector_n;
  logic [8:0] track_n;
  logic [8:0] last_trk;
  logic [3:0] unit_pick_n;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, rv;
  dskp_pkg::dskp_pos_t pos;
  dskp_row_t r;
  dskp_row_t rows [8];
  int failures, n_tests, cyc, n_pos, t_seek, t_acc, t_bad, w_acc, w_bad, t_ack;

  dskp_ctl_model i_ctl (.clock(clock), .track_n(track_n), .seek_n(seek_n),
    .zero_n(zero_n), .unit_pick_n(unit_pick_n));

  dskp_port #(.ZERO_CLEARS_TMO(1'b0), .TIMEOUT_CYC(200)) i_dut (
    .clock(clock), .rst_n(rst_n), .track_n(track_n), .seek_n(seek_n), .zero_n(zero_n),
    .unit_pick_n(unit_pick_n), .platter_n(platter_n), .surface_n(surface_n),
    .supply_n(supply_n), .settled(settled), .fix_sector(fix_sector), .fix_index(1'b0),
    .rem_sector(rem_sector), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .pos(pos), .use_fixed(use_fixed), .use_bottom(use_bottom),
    .done_n(done_n), .timeout_n(timeout_n), .bad_track_pulse_n(bad_track_pulse_n),
    .accept_n(accept_n), .sector_n(sector_n), .fix_sector_n(fix_sector_n));
  // ---------------------------------------------------------------
  // clock, monitors and shared tasks
  // ---------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // pulse start and width seen on the pins, positioner commands
  always @(posedge clock) begin
    cyc <= cyc + 1;
    seek_q <= seek_n;
    acc_q <= accept_n;
    bad_q <= bad_track_pulse_n;
    if (seek_n === 1'b0 && seek_q === 1'b1) t_seek <= cyc;
    if (pos.pos_en === 1'b1) begin
      n_pos <= n_pos + 1;
      last_trk <= pos.pos_track;
      last_zero <= pos.pos_zero;
    end
    if (accept_n === 1'b0) w_acc <= w_acc + 1;
    if (accept_n === 1'b0 && acc_q === 1'b1) t_acc <= cyc;
    if (bad_track_pulse_n === 1'b0) w_bad <= w_bad + 1;
    if (bad_track_pulse_n === 1'b0 && bad_q === 1'b1) t_bad <= cyc;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  // one sector pulse in, the shared line looked at while the pulse stands
  task automatic sect(input bit fx, input logic exp);
    logic seen;
    seen = 1'b0;
    // a platter change needs the pin synchroniser to pass first
    repeat (3) @(posedge clock);
    if (fx) fix_sector <= 1'b1;
    else rem_sector <= 1'b1;
    #1;
    seen = !sector_n;
    @(posedge clock);
    fix_sector <= 1'b0;
    rem_sector <= 1'b0;
    check("sector line", seen, exp);
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // a hang is cut off well past the longest expected run
  initial begin
    repeat (70000) @(posedge clock);
    failures++;
    $display("[ERR] run length expected finish seen hang");
    end_of_test();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {seek_q, acc_q, bad_q, last_zero, last_trk} = '1;
    {cyc, n_pos, t_seek, t_acc, t_bad, w_acc, w_bad, failures, n_tests} = '0;
    {platter_n, surface_n, supply_n} = 3'h7;
    {settled, fix_sector, rem_sector, wr, rd, addr, wdata} = '0;
    rst_n = 1'b0;
    // edge cases of the track range, unsettled runs and an unpicked seek
    rows = '{'{9'h0AA, 1, 0}, '{9'h000, 1, 1}, '{9'h197, 1, 1}, '{9'h198, 1, 1},
      '{9'h1FF, 1, 1}, '{9'h001, 1, 0}, '{9'h055, 0, 1}, '{9'h100, 1, 1}};
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      r = rows[i];
      bad = r.track > dskp_pkg::TRACK_LAST;
      settled <= r.settle;
      {n_pos, w_acc, w_bad} = '0;
      i_ctl.seek(r.track, r.pick, 1'b0, i * 20);
      repeat (dskp_pkg::ACK_DELAY_CYC + dskp_pkg::ACK_WIDTH_CYC + 200) @(posedge clock);
      #1;
      t_ack = bad ? t_bad : t_acc;
      check("pos issued", n_pos != 0, r.pick);
      check("accept width", w_acc, (r.pick && !bad) ? dskp_pkg::ACK_WIDTH_CYC : 0);
      check("bad width", w_bad, (r.pick && bad) ? dskp_pkg::ACK_WIDTH_CYC : 0);
      check("done", done_n, !(r.pick && r.settle));
      if (r.pick) begin
        if (!bad) check("pos track", last_trk, r.track);
        check("pos zero", last_zero, bad);
        check("timeout", timeout_n, !(bad || !r.settle));
        check("ack delay", (t_ack - t_seek) inside
          {[dskp_pkg::ACK_DELAY_CYC:dskp_pkg::ACK_DELAY_CYC + 6]}, 1'b1);
      end
      $display("test seek row %0d done", i);
    end
    rd_reg(dskp_pkg::REG_STATUS, rv);
    check("status", rv, 32'h7);
    check("irq masked", irq, 1'b0);
    wr_reg(dskp_pkg::REG_ENABLE, 32'h2);
    rd_reg(dskp_pkg::REG_ENABLE, rv);
    check("enable", rv, 32'h2);
    check("irq raised", irq, 1'b1);
    rd_reg(4'h1, rv);
    check("unmapped", rv, 32'h0);
    rd_reg(dskp_pkg::REG_TRACK, rv);
    check("track reg", rv[8:0], 9'h100);
    wr_reg(dskp_pkg::REG_CLEAR, 32'hF);
    rd_reg(dskp_pkg::REG_STATUS, rv);
    check("cleared", rv, 32'h0);
    check("irq cleared", irq, 1'b0);
    $display("test registers done");
    n_pos = 0;
    i_ctl.seek(9'h0AA, 1'b1, 1'b1, 0);
    repeat (4) @(posedge clock);
    check("zero request", {n_pos != 0, last_zero}, 2'h3);
    wr_reg(dskp_pkg::REG_ENABLE, 32'h8);
    supply_n <= 1'b0;
    repeat (6) @(posedge clock);
    #1;
    check("retract", pos.retract, 1'b1);
    check("irq retract", irq, 1'b1);
    supply_n <= 1'b1;
    $display("test return and retract done");
    i_ctl.seek(9'h000, 1'b0, 1'b0, 0);
    platter_n <= 1'b0;
    surface_n <= 1'b0;
    repeat (4) @(posedge clock);
    #1;
    check("platter", use_fixed, 1'b1);
    check("surface unpicked", use_bottom, 1'b1);
    i_ctl.seek(9'h000, 1'b1, 1'b0, 0);
    sect(1'b1, 1'b1);
    sect(1'b0, 1'b0);
    platter_n <= 1'b1;
    sect(1'b0, 1'b1);
    check("removable", use_fixed, 1'b0);
    $display("test platter and sector done");
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    check("reset outs", {done_n, timeout_n, accept_n, bad_track_pulse_n, fix_sector_n, irq},
      6'h3E);
    check("reset pos", pos, '0);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    rd_reg(dskp_pkg::REG_STATUS, rv);
    check("status after reset", rv, 32'h0);
    check("done after reset", done_n, 1'b0);
    $display("test mid-run reset done");
    end_of_test();
  end
endmodule
